// ==== bbd_addr_gen.sv ====
// Data address generation for the bit-clear instruction
module bbd_addr_gen
	import bbd_pkg::*;
(
	// Instruction fields
	input wire logic [7:0] file_addr,
	input wire logic acc_sel,
	// Core state
	input wire logic ext_set_en,
	input wire logic [3:0] bank_select_register,
	input wire logic [11:0] index_base,
	// Result
	output logic [11:0] data_addr,
	output logic indexed
);

	wire use_idx;
	wire [11:0] acc_addr;
	wire [11:0] idx_addr;
	wire [11:0] bank_addr;

	// Choice between banked, access bank and indexed forms
	assign use_idx = !acc_sel && ext_set_en && (file_addr <= IDX_LIMIT);
	assign bank_addr = {bank_select_register, file_addr};
	assign acc_addr = (file_addr < ACCESS_SPLIT) ? {4'h0, file_addr} : {ACCESS_HIGH_BANK, file_addr};
	assign idx_addr = index_base + {4'h0, file_addr};
	assign data_addr = acc_sel ? bank_addr : (use_idx ? idx_addr : acc_addr);
	assign indexed = use_idx;

endmodule : bbd_addr_gen

// ==== bbd_core.sv ====
// Decoder and executor for branch on carry, branch on negative and single bit clear
module bbd_core
	import bbd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Instruction word, taken at the start of each cycle except the idle cycle after a taken branch
	input wire logic [15:0] instr,
	// Core state
	input wire bbd_flags_t flags,
	input wire logic ext_set_en,
	input wire logic [3:0] bank_select_register,
	input wire logic [11:0] index_base,
	// Data memory read data
	input wire logic [7:0] mem_rdata,
	// Outputs
	output logic [PC_W-1:0] pc,
	output bbd_phase_t phase,
	output bbd_mem_t mem,
	output logic flush,
	output logic instr_done
);

	bbd_phase_t phase_ff, nxt_phase;
	logic [PC_W-1:0] pc_ff, nxt_pc;
	logic [15:0] ir_ff, nxt_ir;
	logic idle_ff, nxt_idle;
	logic taken_ff, nxt_taken;
	logic [7:0] rd_ff, nxt_rd;
	bbd_mem_t mem_ff, nxt_mem;

	wire is_bc;
	wire is_bn;
	wire is_bcf;
	wire cond;
	wire [2:0] bit_sel;
	wire [7:0] clr_mask;
	wire [11:0] data_addr;
	wire [PC_W-1:0] pc_inc;
	wire [PC_W-1:0] pc_target;

	// Twice the signed offset, extended to PC width
	function automatic logic [PC_W-1:0] dbl_off(input logic [7:0] n);
		dbl_off = {{(PC_W-9){n[7]}}, n, 1'b0};
	endfunction : dbl_off

	////////////////////////////////////////////////////////////////
	// Decode
	assign is_bc = !idle_ff && (ir_ff[15:8] == OP_BRANCH_ON_CARRY);
	assign is_bn = !idle_ff && (ir_ff[15:8] == OP_BRANCH_ON_NEGATIVE);
	assign is_bcf = !idle_ff && (ir_ff[15:12] == OP_SINGLE_BIT_CLEAR);
	assign cond = (is_bc && flags.carry) || (is_bn && flags.negative);
	assign bit_sel = ir_ff[BIT_SEL_LSB+2:BIT_SEL_LSB];
	assign clr_mask = ~(8'h01 << bit_sel);
	assign pc_inc = pc_ff + PC_STEP;
	assign pc_target = pc_inc + dbl_off(ir_ff[7:0]);

	bbd_addr_gen u_addr
	(
		.file_addr(ir_ff[7:0]),
		.acc_sel(ir_ff[ACC_SEL_POS]),
		.ext_set_en(ext_set_en),
		.bank_select_register(bank_select_register),
		.index_base(index_base),
		.data_addr(data_addr),
		.indexed()
	);

	////////////////////////////////////////////////////////////////
	// Phase sequencing and per-phase work
	always_comb
	begin
		nxt_phase = phase_ff;
		nxt_pc = pc_ff;
		nxt_ir = ir_ff;
		nxt_idle = idle_ff;
		nxt_taken = taken_ff;
		nxt_rd = rd_ff;
		nxt_mem = '0;
		case (phase_ff)
			PH_Q1:
			begin
				nxt_phase = PH_Q2;
				if (is_bcf)
				begin
					nxt_mem.rd = 1'b1; // Read register f in Q2
					nxt_mem.addr = data_addr;
				end
			end
			PH_Q2:
			begin
				nxt_phase = PH_Q3;
				nxt_rd = mem_rdata;
				nxt_taken = cond;
			end
			PH_Q3:
			begin
				nxt_phase = PH_Q4;
				if (is_bcf)
				begin
					nxt_mem.wr = 1'b1; // Write back in Q4
					nxt_mem.addr = data_addr;
					nxt_mem.wdata = rd_ff & clr_mask;
				end
			end
			PH_Q4:
			begin
				nxt_phase = PH_Q1;
				if (idle_ff)
				begin
					nxt_idle = 1'b0; // Idle cycle over, fetch resumes
					nxt_ir = instr;
				end
				else if (taken_ff)
				begin
					nxt_pc = pc_target;
					nxt_idle = 1'b1; // Second cycle does nothing
				end
				else
				begin
					nxt_pc = pc_inc; // Not taken or bit clear: one cycle
					nxt_ir = instr;
				end
				nxt_taken = 1'b0;
			end
			default:
			begin
				nxt_phase = PH_Q1;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			phase_ff <= PH_Q4;
			pc_ff <= PC_RESET;
			ir_ff <= 16'h0000;
			idle_ff <= 1'b1;
			taken_ff <= 1'b0;
			rd_ff <= 8'h00;
			mem_ff <= '0;
		end
		else
		begin
			phase_ff <= nxt_phase;
			pc_ff <= nxt_pc;
			ir_ff <= nxt_ir;
			idle_ff <= nxt_idle;
			taken_ff <= nxt_taken;
			rd_ff <= nxt_rd;
			mem_ff <= nxt_mem;
		end
	end

	// Outputs
	assign pc = pc_ff;
	assign phase = phase_ff;
	assign mem = mem_ff;
	assign flush = idle_ff;
	assign instr_done = (phase_ff == PH_Q4) && !taken_ff && !idle_ff;

	////////////////////////////////////////////////////////////////
	// Checks
	sequence taken_q4_s;
		(phase_ff == PH_Q4) && taken_ff && !idle_ff;
	endsequence

	property taken_target_p;
		@(posedge clk) disable iff (sys_rst)
		taken_q4_s |=> (pc_ff == $past(pc_target)) && idle_ff;
	endproperty
	branch_target_a: assert property (taken_target_p) else $error("taken branch target wrong");

	property idle_len_p;
		@(posedge clk) disable iff (sys_rst)
		taken_q4_s |=> (idle_ff && !mem_ff.wr && !mem_ff.rd) [*4] ##1 !idle_ff;
	endproperty
	taken_idle_a: assert property (idle_len_p) else $error("idle cycle not four phases");

	untaken_step_a: assert property (@(posedge clk) disable iff (sys_rst)
		(phase_ff == PH_Q4) && !taken_ff && !idle_ff |=> pc_ff == $past(pc_ff) + PC_STEP)
		else $error("untaken pc step wrong");

	bc_cond_a: assert property (@(posedge clk) disable iff (sys_rst)
		(phase_ff == PH_Q2) && is_bc && !flags.carry |=> !taken_ff)
		else $error("branch taken without carry");

	bn_cond_a: assert property (@(posedge clk) disable iff (sys_rst)
		(phase_ff == PH_Q2) && is_bn && !flags.negative |=> !taken_ff)
		else $error("branch taken without negative");

	branch_q4_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
		(phase_ff == PH_Q4) && (is_bc || is_bn) |-> !mem_ff.wr && !mem_ff.rd)
		else $error("branch touched memory in last phase");

	clear_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
		mem_ff.wr |-> mem_ff.wdata[bit_sel] == 1'b0 && (mem_ff.wdata | ~clr_mask) == (rd_ff | ~clr_mask))
		else $error("bit clear data wrong");

	bank_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
		(phase_ff == PH_Q1) && is_bcf && ir_ff[ACC_SEL_POS] |=> mem_ff.addr == {bank_select_register, ir_ff[7:0]})
		else $error("banked address wrong");

	idx_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
		(phase_ff == PH_Q1) && is_bcf && !ir_ff[ACC_SEL_POS] && ext_set_en && ir_ff[7:0] <= IDX_LIMIT
		|=> mem_ff.addr == index_base + {4'h0, ir_ff[7:0]})
		else $error("indexed address wrong");

	access_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
		(phase_ff == PH_Q1) && is_bcf && !ir_ff[ACC_SEL_POS] && !ext_set_en && ir_ff[7:0] < ACCESS_SPLIT
		|=> mem_ff.addr == {4'h0, ir_ff[7:0]})
		else $error("access bank address wrong");

endmodule : bbd_core

// ==== bbd_pkg.sv ====
// Package with opcodes, field positions and address constants for the branch and bit-clear decoder
package bbd_pkg;

	localparam int PC_W = 21;
	localparam logic [7:0] OP_BRANCH_ON_CARRY = 8'hE2;
	localparam logic [7:0] OP_BRANCH_ON_NEGATIVE = 8'hE6;
	localparam logic [3:0] OP_SINGLE_BIT_CLEAR = 4'h9;
	localparam int BIT_SEL_LSB = 9;
	localparam int ACC_SEL_POS = 8;
	localparam logic [7:0] IDX_LIMIT = 8'h5F;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;

	// Quarter phases of one instruction cycle
	typedef enum logic [3:0]
	{
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} bbd_phase_t;

	// Data-memory access request for the bit clear
	typedef struct packed
	{
		logic rd;
		logic wr;
		logic [11:0] addr;
		logic [7:0] wdata;
	} bbd_mem_t;

	// Status flags that the branches test
	typedef struct packed
	{
		logic carry;
		logic negative;
	} bbd_flags_t;

endpackage : bbd_pkg

// ==== branch_bitclear_decode_tb.sv ====
// Self-checking testbench for the branch and bit-clear decoder
module branch_bitclear_decode_tb
	import bbd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] instr = 16'h0000;
	bbd_flags_t flags = 2'b00;
	logic ext_set_en = 1'b0;
	logic [3:0] bank_select_register = 4'h0;
	logic [11:0] index_base = 12'h000;
	logic [7:0] mem_rdata = 8'h00;
	logic [PC_W-1:0] pc;
	bbd_phase_t phase;
	bbd_mem_t mem;
	logic flush;
	logic instr_done;
	int fail_count = 0;
	int checks_done = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and design
	always #10 clk = ~clk;

	bbd_core dut (.clk(clk), .sys_rst(sys_rst), .instr(instr), .flags(flags), .ext_set_en(ext_set_en),
		.bank_select_register(bank_select_register), .index_base(index_base), .mem_rdata(mem_rdata),
		.pc(pc), .phase(phase), .mem(mem), .flush(flush), .instr_done(instr_done));

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
		checks_done++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk

	// Inputs change one nanosecond after each rising edge
	task automatic step();
		@(posedge clk);
		#1;
	endtask : step

	// Run one instruction through all phases and judge its effects
	task automatic exec(input logic [15:0] w, input bbd_flags_t fl, input logic [7:0] rd,
		input logic [11:0] ea, input logic tk);
		logic [PC_W-1:0] p0;
		logic bclr;
		int n;
		bclr = (w[15:12] === OP_SINGLE_BIT_CLEAR);
		n = 0;
		while (!(phase === PH_Q4 && (instr_done === 1'b1 || flush === 1'b1)))
		begin
			n++;
			if (n > 16)
			begin
				fail_count++;
				final_report();
			end
			step();
		end
		instr = w;
		flags = fl;
		mem_rdata = rd;
		step();
		p0 = pc;
		chk("phase", 21'(PH_Q1), 21'(phase));
		step();
		chk("read strobe", 21'(bclr), 21'(mem.rd));
		if (bclr)
			chk("address", 21'(ea), 21'(mem.addr));
		step();
		step();
		chk("write strobe", 21'(bclr), 21'(mem.wr));
		chk("done", 21'(!tk), 21'(instr_done));
		if (bclr)
			chk("write data", 21'(rd & ~(8'h01 << w[11:9])), 21'(mem.wdata));
		// A filler word keeps the next fetch from repeating this one
		instr = 16'h0000;
		step();
		chk("pc", tk ? p0 + PC_STEP + {{12{w[7]}}, w[7:0], 1'b0} : p0 + PC_STEP, pc);
		// Taken branch: four idle phases, nothing touches memory
		for (int i = 0; i < 4 && tk; i++)
		begin
			chk("flush", 21'(1'b1), 21'(flush));
			chk("idle access", 21'(2'b00), 21'({mem.rd, mem.wr}));
			if (i < 3)
				step();
		end
	endtask : exec

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_carry();
		exec({OP_BRANCH_ON_CARRY, 8'h05}, 2'b10, 8'h00, 12'h000, 1'b1);
		exec({OP_BRANCH_ON_CARRY, 8'h80}, 2'b10, 8'h00, 12'h000, 1'b1);
		exec({OP_BRANCH_ON_CARRY, 8'h7F}, 2'b01, 8'h00, 12'h000, 1'b0);
		$display("test carry branch done");
	endtask : t_carry

	task automatic t_negative();
		exec({OP_BRANCH_ON_NEGATIVE, 8'hFD}, 2'b01, 8'h00, 12'h000, 1'b1);
		exec({OP_BRANCH_ON_NEGATIVE, 8'h7F}, 2'b10, 8'h00, 12'h000, 1'b0);
		exec({OP_BRANCH_ON_NEGATIVE, 8'h7F}, 2'b11, 8'h00, 12'h000, 1'b1);
		exec(16'hE37F, 2'b00, 8'h00, 12'h000, 1'b0);
		$display("test negative branch done");
	endtask : t_negative

	task automatic t_clear();
		bank_select_register = 4'hA;
		index_base = 12'h3F0;
		ext_set_en = 1'b1;
		exec(16'h9F33, 2'b11, 8'hC7, 12'hA33, 1'b0);
		exec(16'h905F, 2'b00, 8'hFF, 12'h44F, 1'b0);
		exec(16'h9A60, 2'b00, 8'hFF, 12'hF60, 1'b0);
		ext_set_en = 1'b0;
		exec(16'h9410, 2'b00, 8'h0F, 12'h010, 1'b0);
		$display("test bit clear done");
	endtask : t_clear

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		t_carry();
		t_negative();
		t_clear();
		final_report();
	end

endmodule : branch_bitclear_decode_tb
